// ---- rtl/sma_debounce.sv ----
// Purpose: Two-stage synchroniser and stability filter for one pin.
// Assumes: Pin is asynchronous to core_clk.
// Notes:   Level changes only after CNT stable cycles; edge pulses last one cycle.
`timescale 1ns/100ps
module sma_debounce #(
  parameter int CNT = 1
) (
  input  wire logic core_clk,  // Core clock.
  input  wire logic rstn,      // Asynchronous reset, active low.
  input  wire logic pin,       // Raw pin.
  output logic      level,     // Filtered level.
  output logic      rise,      // One-cycle pulse on a filtered rise.
  output logic      fall       // One-cycle pulse on a filtered fall.
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);

  logic          sync1_ff, sync2_ff, level_ff, rise_ff, fall_ff;
  logic          nxt_level, nxt_rise, nxt_fall;
  logic [CW-1:0] cnt_ff, nxt_cnt;

  // Counts cycles of disagreement and flips the level once it has lasted.
  always_comb begin
    nxt_level = level_ff;
    nxt_rise  = 1'b0;
    nxt_fall  = 1'b0;
    nxt_cnt   = '0;
    if (sync2_ff != level_ff) begin
      if (cnt_ff == LAST) begin
        nxt_level = sync2_ff;
        nxt_rise  = sync2_ff;
        nxt_fall  = ~sync2_ff;
      end else begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  // Registers the synchroniser and the filter.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      level_ff <= nxt_level;
      rise_ff  <= nxt_rise;
      fall_ff  <= nxt_fall;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign level = level_ff;
  assign rise  = rise_ff;
  assign fall  = fall_ff;
endmodule : sma_debounce

// ---- rtl/sma_pkg.sv ----
// Purpose: Shared constants, types and register map of the servo mode and alarm block.
// Assumes: One 25 MHz core clock; registers reached over AXI4-Lite with 32-bit data.
// Notes:   Alarm codes are kept as three BCD digits, major then minor.
package sma_pkg;

  // Clock and debounce timing.
  localparam int CLK_HZ   = 25_000_000;
  localparam int DEB_US   = 100;
  localparam int DEB_CYC  = (CLK_HZ / 1_000_000) * DEB_US;
  localparam int FAST_CYC = 1;

  // Register bus geometry and byte offsets.
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_CONFIG  = 8'h00;
  localparam logic [7:0]  REG_PULSE   = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam logic [7:0]  REG_IRQ_ST  = 8'h0c;
  localparam logic [7:0]  REG_IRQ_MSK = 8'h10;
  localparam logic [7:0]  REG_COMMAND = 8'h14;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Mode configuration low digit codes and reset values.
  localparam logic [3:0]  MODE_SPD_TRQ  = 4'h3;
  localparam logic [3:0]  MODE_TRQ_POS  = 4'h5;
  localparam logic [3:0]  CFG_RESET     = 4'h3;
  localparam logic [15:0] PULSE_SET_RST = 16'h0010;
  localparam logic [1:0]  PULSE_SEL_RST = 2'h0;

  // Field positions.
  localparam int PULSE_SEL_LSB = 16;
  localparam int ST_ALARM_BIT  = 4;
  localparam int ST_BASE_BIT   = 5;
  localparam int ST_CODE_LSB   = 16;
  localparam int CMD_SETKEY    = 0;

  // Alarm codes.
  localparam logic [11:0] ALM_NONE  = 12'h000;
  localparam logic [11:0] ALM_UV    = 12'h101;
  localparam logic [11:0] ALM_REGEN = 12'h300;
  localparam logic [11:0] ALM_OC    = 12'h320;
  localparam logic [11:0] ALM_OL1   = 12'h500;
  localparam logic [11:0] ALM_OL2   = 12'h510;

  // Interrupt status bits.
  localparam int IRQ_W       = 3;
  localparam int IRQ_ALARM   = 0;
  localparam int IRQ_MODE    = 1;
  localparam int IRQ_REFUSED = 2;

  // Pin indices inside the synchronised pin vector.
  localparam int NPINS    = 12;
  localparam int PIN_SEL  = 0;
  localparam int PIN_ARST = 1;
  localparam int PIN_SON  = 2;
  localparam int PIN_STF  = 3;
  localparam int PIN_STR  = 4;
  localparam int PIN_ZSP  = 5;
  localparam int PIN_OC   = 6;
  localparam int PIN_OL1  = 7;
  localparam int PIN_OL2  = 8;
  localparam int PIN_RGN  = 9;
  localparam int PIN_PWR  = 10;
  localparam int PIN_CMDP = 11;

  // Active servo control mode.
  typedef enum logic [3:0] {
    CM_IDLE     = 4'b0001,
    CM_SPEED    = 4'b0010,
    CM_TORQUE   = 4'b0100,
    CM_POSITION = 4'b1000
  } sma_mode_t;

  // Contact and fault pins; the last field lands on bit 0.
  typedef struct packed {
    logic cmd_pulse_in;
    logic ctrl_power_ok;
    logic regen_fault;
    logic overload2_fault;
    logic overload1_fault;
    logic overcurrent_fault;
    logic zero_speed_flag;
    logic start_reverse_input;
    logic start_forward_input;
    logic servo_on_input;
    logic alarm_reset_input;
    logic control_select_input;
  } sma_pins_t;

  // Drive-side outputs.
  typedef struct packed {
    logic      base_drive_on;
    logic      decel_stop;
    logic      droop_clear;
    logic      cmd_pulse_accept;
    logic      enc_pulse_out;
    sma_mode_t mode;
  } sma_drive_t;

endpackage : sma_pkg

// ---- rtl/sma_top.sv ----
// Purpose: Control-mode selection and alarm sequencing of a servo driver.
// Assumes: Single core clock; power-on reset on rstn stands for a control power cycle.
// Notes:   Speed, torque and position loops live elsewhere and obey the mode output.
`timescale 1ns/100ps
module sma_top
  import sma_pkg::*;
(
  input  wire logic              core_clk,       // Core clock, 25 MHz.
  input  wire logic              rstn,           // Asynchronous reset, active low.
  input  wire sma_pins_t         pins,           // Contact, fault and pulse pins.
  output sma_drive_t             drive,          // Mode and drive-side controls.
  output logic                   irq,            // Level interrupt.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address.
  input  wire logic              s_axi_awvalid,  // Write address valid.
  output logic                   s_axi_awready,  // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,    // Write data.
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte enables.
  input  wire logic              s_axi_wvalid,   // Write data valid.
  output logic                   s_axi_wready,   // Write data ready.
  output logic [1:0]             s_axi_bresp,    // Write response.
  output logic                   s_axi_bvalid,   // Write response valid.
  input  wire logic              s_axi_bready,   // Write response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address.
  input  wire logic              s_axi_arvalid,  // Read address valid.
  output logic                   s_axi_arready,  // Read address ready.
  output logic [31:0]            s_axi_rdata,    // Read data.
  output logic [1:0]             s_axi_rresp,    // Read response.
  output logic                   s_axi_rvalid,   // Read data valid.
  input  wire logic              s_axi_rready    // Read data ready.
);

  // Synchronised pin levels and edges.
  logic [NPINS-1:0] pin_raw, lvl, rse, fll;
  assign pin_raw = pins;

  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    localparam int C = (g <= PIN_ARST) ? DEB_CYC : FAST_CYC;
    sma_debounce #(.CNT(C)) u_deb (
      .core_clk (core_clk),
      .rstn     (rstn),
      .pin      (pin_raw[g]),
      .level    (lvl[g]),
      .rise     (rse[g]),
      .fall     (fll[g])
    );
  end

  // Register bus state.
  logic              awr_ff, wr_ff, bvalid_ff, rvalid_ff, awrdy_ff, wrdy_ff, arrdy_ff;
  logic              nxt_awr, nxt_wr, nxt_bvalid, nxt_rvalid, nxt_awrdy, nxt_wrdy, nxt_arrdy;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0]       wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [3:0]        cfg_ff, nxt_cfg;
  logic [15:0]       pset_ff, nxt_pset;
  logic [1:0]        psel_ff, nxt_psel;
  logic [IRQ_W-1:0]  ist_ff, nxt_ist, imsk_ff, nxt_imsk, ev;
  logic              setkey_ff, nxt_setkey, irq_ff, nxt_irq;
  logic              do_wr, do_rd, rd_clr;

  // Control state.
  sma_mode_t   mode_ff, nxt_mode;
  logic        alarm_ff, nxt_alarm, uv_armed_ff, nxt_uv_armed;
  logic [11:0] code_ff, nxt_code, new_code;
  logic        base_ff, nxt_base, decel_ff, nxt_decel, droop_ff, nxt_droop;
  logic        cmd_ff, nxt_cmd, enc_ff, nxt_enc, cause_now, clr_req;
  logic [18:0] enc_cnt_ff, nxt_enc_cnt, half_per;

  // Register bus: write channels taken in either order, read answered next cycle.
  always_comb begin
    nxt_awr    = awr_ff;
    nxt_wr     = wr_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    do_wr      = 1'b0;
    do_rd      = 1'b0;
    if (s_axi_awvalid && awrdy_ff) begin
      nxt_awr    = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_ff) begin
      nxt_wr    = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (awr_ff && wr_ff && !bvalid_ff) begin
      do_wr      = 1'b1;
      nxt_awr    = 1'b0;
      nxt_wr     = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = RESP_OKAY;
      if (!(awaddr_ff inside {REG_CONFIG, REG_PULSE, REG_STATUS, REG_IRQ_ST,
                              REG_IRQ_MSK, REG_COMMAND})) begin
        nxt_bresp = RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && arrdy_ff) begin
      do_rd      = 1'b1;
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = '0;
      unique case (s_axi_araddr)
        REG_CONFIG:  nxt_rdata[3:0] = cfg_ff;
        REG_PULSE:   nxt_rdata = {14'h0000, psel_ff, pset_ff};
        REG_STATUS: begin
          nxt_rdata[3:0]                        = mode_ff;
          nxt_rdata[ST_ALARM_BIT]               = alarm_ff;
          nxt_rdata[ST_BASE_BIT]                = base_ff;
          nxt_rdata[ST_CODE_LSB +: 12]          = code_ff;
        end
        REG_IRQ_ST:  nxt_rdata[IRQ_W-1:0] = ist_ff;
        REG_IRQ_MSK: nxt_rdata[IRQ_W-1:0] = imsk_ff;
        REG_COMMAND: nxt_rdata = '0;
        default:     nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_awrdy = !nxt_awr && !nxt_bvalid;
    nxt_wrdy  = !nxt_wr && !nxt_bvalid;
    nxt_arrdy = !nxt_rvalid;
    rd_clr    = do_rd && (s_axi_araddr == REG_IRQ_ST);
  end

  // Software-written registers and the interrupt status.
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_pset   = pset_ff;
    nxt_psel   = psel_ff;
    nxt_imsk   = imsk_ff;
    nxt_setkey = 1'b0;
    if (do_wr && wstrb_ff[0]) begin
      unique case (awaddr_ff)
        REG_CONFIG:  nxt_cfg = wdata_ff[3:0];
        REG_PULSE:   nxt_pset[7:0] = wdata_ff[7:0];
        REG_IRQ_MSK: nxt_imsk = wdata_ff[IRQ_W-1:0];
        REG_COMMAND: nxt_setkey = wdata_ff[CMD_SETKEY];
        default:     nxt_cfg = cfg_ff;
      endcase
    end
    if (do_wr && awaddr_ff == REG_PULSE) begin
      if (wstrb_ff[1]) nxt_pset[15:8] = wdata_ff[15:8];
      if (wstrb_ff[2]) nxt_psel = wdata_ff[PULSE_SEL_LSB +: 2];
    end
    // A read clears the status, but an event in the same cycle stays set.
    nxt_ist = (rd_clr ? '0 : ist_ff) | ev;
    nxt_irq = |(nxt_ist & nxt_imsk);
  end

  // Alarm raising, clearing and base drive.
  always_comb begin
    new_code = ALM_NONE;
    if (rse[PIN_OC])
      new_code = ALM_OC;
    else if (rse[PIN_OL1])
      new_code = ALM_OL1;
    else if (rse[PIN_OL2])
      new_code = ALM_OL2;
    else if (rse[PIN_RGN])
      new_code = ALM_REGEN;
    else if (rse[PIN_PWR] && uv_armed_ff)
      new_code = ALM_UV;
    nxt_uv_armed = fll[PIN_PWR] | (uv_armed_ff & ~rse[PIN_PWR]);
    unique case (code_ff)
      ALM_OC:    cause_now = lvl[PIN_OC];
      ALM_OL1:   cause_now = lvl[PIN_OL1];
      ALM_OL2:   cause_now = lvl[PIN_OL2];
      ALM_REGEN: cause_now = lvl[PIN_RGN];
      ALM_UV:    cause_now = ~lvl[PIN_PWR];
      default:   cause_now = 1'b0;
    endcase
    clr_req   = setkey_ff | rse[PIN_ARST];
    nxt_alarm = alarm_ff;
    nxt_code  = code_ff;
    if (!alarm_ff && new_code != ALM_NONE) begin
      nxt_alarm = 1'b1;
      nxt_code  = new_code;
    end else if (alarm_ff && clr_req && !cause_now) begin
      // A fault rising in the clearing cycle wins over the clear.
      nxt_alarm = (new_code != ALM_NONE);
      nxt_code  = new_code;
    end
    nxt_base = lvl[PIN_SON] & ~nxt_alarm;
  end

  // Control mode selection.
  always_comb begin
    nxt_mode = mode_ff;
    ev       = '0;
    unique case (cfg_ff)
      MODE_SPD_TRQ: nxt_mode = lvl[PIN_SEL] ? CM_TORQUE : CM_SPEED;
      MODE_TRQ_POS: begin
        if (mode_ff != CM_TORQUE && mode_ff != CM_POSITION) begin
          nxt_mode = lvl[PIN_SEL] ? CM_POSITION : CM_TORQUE;
        end else if (rse[PIN_SEL] || fll[PIN_SEL]) begin
          if (lvl[PIN_ZSP])
            nxt_mode = lvl[PIN_SEL] ? CM_POSITION : CM_TORQUE;
          else
            ev[IRQ_REFUSED] = 1'b1;
        end
      end
      default: nxt_mode = CM_IDLE;
    endcase
    ev[IRQ_MODE]  = (nxt_mode != mode_ff);
    ev[IRQ_ALARM] = nxt_alarm & ~alarm_ff;
    nxt_droop = (mode_ff == CM_POSITION) && (nxt_mode == CM_TORQUE);
    nxt_decel = (mode_ff == CM_SPEED) && !lvl[PIN_STF] && !lvl[PIN_STR];
    nxt_cmd = rse[PIN_CMDP] && (mode_ff == CM_POSITION) && !alarm_ff;
  end

  always_comb begin
    half_per    = 19'({3'b000, pset_ff} << psel_ff);
    nxt_enc     = enc_ff;
    nxt_enc_cnt = enc_cnt_ff + 19'h00001;
    if (half_per == '0) begin
      nxt_enc     = 1'b0;
      nxt_enc_cnt = '0;
    end else if (enc_cnt_ff >= half_per - 19'h00001) begin
      nxt_enc     = ~enc_ff;
      nxt_enc_cnt = '0;
    end
  end

  // Registers all state of the block.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awr_ff      <= 1'b0;
      wr_ff       <= 1'b0;
      awaddr_ff   <= '0;
      wdata_ff    <= '0;
      wstrb_ff    <= '0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= RESP_OKAY;
      rvalid_ff   <= 1'b0;
      rresp_ff    <= RESP_OKAY;
      rdata_ff    <= '0;
      awrdy_ff    <= 1'b0;
      wrdy_ff     <= 1'b0;
      arrdy_ff    <= 1'b0;
      cfg_ff      <= CFG_RESET;
      pset_ff     <= PULSE_SET_RST;
      psel_ff     <= PULSE_SEL_RST;
      imsk_ff     <= '0;
      ist_ff      <= '0;
      setkey_ff   <= 1'b0;
      irq_ff      <= 1'b0;
      mode_ff     <= CM_IDLE;
      alarm_ff    <= 1'b0;
      code_ff     <= ALM_NONE;
      uv_armed_ff <= 1'b0;
      base_ff     <= 1'b0;
      decel_ff    <= 1'b0;
      droop_ff    <= 1'b0;
      cmd_ff      <= 1'b0;
      enc_ff      <= 1'b0;
      enc_cnt_ff  <= '0;
    end else begin
      awr_ff      <= nxt_awr;
      wr_ff       <= nxt_wr;
      awaddr_ff   <= nxt_awaddr;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      rvalid_ff   <= nxt_rvalid;
      rresp_ff    <= nxt_rresp;
      rdata_ff    <= nxt_rdata;
      awrdy_ff    <= nxt_awrdy;
      wrdy_ff     <= nxt_wrdy;
      arrdy_ff    <= nxt_arrdy;
      cfg_ff      <= nxt_cfg;
      pset_ff     <= nxt_pset;
      psel_ff     <= nxt_psel;
      imsk_ff     <= nxt_imsk;
      ist_ff      <= nxt_ist;
      setkey_ff   <= nxt_setkey;
      irq_ff      <= nxt_irq;
      mode_ff     <= nxt_mode;
      alarm_ff    <= nxt_alarm;
      code_ff     <= nxt_code;
      uv_armed_ff <= nxt_uv_armed;
      base_ff     <= nxt_base;
      decel_ff    <= nxt_decel;
      droop_ff    <= nxt_droop;
      cmd_ff      <= nxt_cmd;
      enc_ff      <= nxt_enc;
      enc_cnt_ff  <= nxt_enc_cnt;
    end
  end

  // Outputs straight from flip-flops.
  assign drive.base_drive_on    = base_ff;
  assign drive.decel_stop       = decel_ff;
  assign drive.droop_clear      = droop_ff;
  assign drive.cmd_pulse_accept = cmd_ff;
  assign drive.enc_pulse_out    = enc_ff;
  assign drive.mode             = mode_ff;
  assign irq                    = irq_ff;
  assign s_axi_awready          = awrdy_ff;
  assign s_axi_wready           = wrdy_ff;
  assign s_axi_bresp            = bresp_ff;
  assign s_axi_bvalid           = bvalid_ff;
  assign s_axi_arready          = arrdy_ff;
  assign s_axi_rdata            = rdata_ff;
  assign s_axi_rresp            = rresp_ff;
  assign s_axi_rvalid           = rvalid_ff;

endmodule : sma_top

// ---- testbench/sma_ctrl_model.sv ----
// Purpose: External controller model driving contacts and the command pulse train.
// Assumes: The bench sets wanted contact levels by non-blocking assignment.
// Notes:   No pulses leave the model while run is low.
`timescale 1ns/100ps
module sma_ctrl_model
  import sma_pkg::*;
(
  input  wire logic      core_clk,  // Core clock.
  input  wire logic      rstn,      // Reset, active low.
  input  wire sma_pins_t want,      // Wanted contact levels.
  input  wire logic      run,       // Pulse train enable.
  output sma_pins_t      pins       // Pins seen by the block.
);
  logic [2:0] div_ff;
  logic [2:0] nxt_div;

  // Pulse divider steps only while the train runs.
  always_comb begin
    nxt_div = run ? div_ff + 3'h1 : 3'h0;
  end

  // Divider register.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  always_comb begin
    pins = want;
    pins.cmd_pulse_in = div_ff[2];
  end
endmodule : sma_ctrl_model

// ---- testbench/sma_top_bench.sv ----
// Purpose: Self-checking bench of the servo mode and alarm block.
// Assumes: 25 MHz clock; registers reached by an AXI4-Lite master task.
// Notes:   Each select or reset contact toggle waits out the full debounce time.
`timescale 1ns/100ps
module sma_top_bench
  import sma_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  sma_pins_t   want, pins;
  sma_drive_t  drive;
  logic        run, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [11:0] codes [4] = '{ALM_OC, ALM_OL1, ALM_OL2, ALM_REGEN};
  int          n_mismatch = 0, samples_checked = 0, cyc = 0, n_acc = 0, n_droop = 0, i;

  sma_ctrl_model sma_ctrl_model_inst (
    .core_clk(core_clk), .rstn(rstn), .want(want), .run(run), .pins(pins));
  sma_top sma_top_inst (
    .core_clk(core_clk), .rstn(rstn), .pins(pins), .drive(drive), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Clock of 40 ns period.
  always #20 core_clk = ~core_clk;

  // Cycle watchdog and pulse monitors.
  always @(posedge core_clk) begin
    cyc++;
    if (drive.cmd_pulse_accept === 1'b1) n_acc++;
    if (drive.droop_clear === 1'b1) n_droop++;
    if (cyc == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic mode_is(input sma_mode_t m);
    chk({28'h0, drive.mode}, {28'h0, m});
  endtask : mode_is

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Status word from mode, alarm, base drive and code.
  function automatic logic [31:0] st(sma_mode_t m, logic al, logic bd, logic [11:0] c);
    return {4'h0, c, 10'h0, bd, al, m};
  endfunction : st

  // Write with both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask : wr

  // Read and compare data and response.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask : rd_reg

  task automatic sel(input logic v);
    @(posedge core_clk);
    want.control_select_input <= v;
    tick(DEB_CYC + 20);
  endtask : sel

  task automatic press();
    @(posedge core_clk);
    want.alarm_reset_input <= 1'b1;
    tick(DEB_CYC + 20);
    want.alarm_reset_input <= 1'b0;
    tick(DEB_CYC + 20);
  endtask : press

  // Measure one half period of the encoder output after a new setting.
  task automatic enc(input logic [15:0] s, input logic [1:0] p);
    logic v;
    int   n;
    wr(REG_PULSE, {14'h0, p, s}, RESP_OKAY);
    repeat (2) begin
      v = drive.enc_pulse_out;
      @(posedge core_clk iff drive.enc_pulse_out !== v);
    end
    v = drive.enc_pulse_out;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (drive.enc_pulse_out === v);
    chk(n, 32'(s) << p);
  endtask : enc

  // Main sequence.
  initial begin
    want = '0;
    want.ctrl_power_ok = 1'b1;
    want.servo_on_input = 1'b1;
    {run, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    void'($urandom(32'h131b));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    tick(DEB_CYC + 20);
    rd_reg(REG_CONFIG, 32'h3, RESP_OKAY);
    rd_reg(REG_STATUS, st(CM_SPEED, 1'b0, 1'b1, ALM_NONE), RESP_OKAY);
    rd_reg(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h5, RESP_SLVERR);
    chk1(drive.decel_stop, 1'b1);
    wr(REG_IRQ_MSK, 32'h7, RESP_OKAY);
    sel(1'b1);
    mode_is(CM_TORQUE);
    chk1(irq, 1'b1);
    sel(1'b0);
    mode_is(CM_SPEED);
    chk1(drive.decel_stop, 1'b1);
    rd_reg(REG_IRQ_ST, 32'h2, RESP_OKAY);
    want.start_forward_input <= 1'b1;
    tick(10);
    chk1(drive.decel_stop, 1'b0);
    want.zero_speed_flag <= 1'b1;
    run <= 1'b1;
    wr(REG_CONFIG, 32'h5, RESP_OKAY);
    tick(4);
    mode_is(CM_TORQUE);
    sel(1'b1);
    mode_is(CM_POSITION);
    rd_reg(REG_IRQ_ST, 32'h2, RESP_OKAY);
    chk1(n_acc > 0, 1'b1);
    wr(REG_IRQ_MSK, 32'h3, RESP_OKAY);
    want.zero_speed_flag <= 1'b0;
    sel(1'b0);
    mode_is(CM_POSITION);
    want.zero_speed_flag <= 1'b1;
    tick(20);
    mode_is(CM_POSITION);
    chk1(irq, 1'b0);
    rd_reg(REG_IRQ_ST, 32'h4, RESP_OKAY);
    sel(1'b1);
    sel(1'b0);
    mode_is(CM_TORQUE);
    chk(n_droop, 32'h1);
    sel(1'b1);
    rd_reg(REG_IRQ_ST, 32'h2, RESP_OKAY);
    // Each fault in turn, cleared by reset contact or set key.
    for (i = 0; i < 4; i++) begin
      want[PIN_OC + i] <= 1'b1;
      tick(10);
      chk1(drive.base_drive_on, 1'b0);
      rd_reg(REG_STATUS, st(CM_POSITION, 1'b1, 1'b0, codes[i]), RESP_OKAY);
      if (i == 0) begin
        chk1(irq, 1'b1);
        rd_reg(REG_IRQ_ST, 32'h1, RESP_OKAY);
        n_acc = 0;
        tick(100);
        chk(n_acc, 32'h0);
        press();
        chk1(drive.base_drive_on, 1'b0);
      end
      want[PIN_OC + i] <= 1'b0;
      tick(10);
      if (i % 2 == 1) wr(REG_COMMAND, 32'h1, RESP_OKAY);
      else press();
      tick(10);
      chk1(drive.base_drive_on, 1'b1);
    end
    want.ctrl_power_ok <= 1'b0;
    tick(10);
    want.ctrl_power_ok <= 1'b1;
    tick(10);
    rd_reg(REG_STATUS, st(CM_POSITION, 1'b1, 1'b0, ALM_UV), RESP_OKAY);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(DEB_CYC + 20);
    rd_reg(REG_STATUS, st(CM_TORQUE, 1'b0, 1'b1, ALM_NONE), RESP_OKAY);
    enc(16'h1, 2'h3);
    repeat (2) enc(16'(2 + $urandom % 6), 2'($urandom % 4));
    report_and_stop();
  end
endmodule : sma_top_bench

// ---- testbench/sma_top_properties.sv ----
// Purpose: Port-level properties of the servo mode and alarm block.
// Assumes: Faults and zero speed are held steady for many cycles at a time.
// Notes:   Bound into sma_top at the foot of this file.
`timescale 1ns/100ps
module sma_top_properties
  import sma_pkg::*;
(
  input wire logic       core_clk,       // Core clock.
  input wire logic       rstn,           // Reset, active low.
  input wire sma_pins_t  pins,           // Pins.
  input wire sma_drive_t drive,          // Drive outputs.
  input wire logic       s_axi_awvalid,  // Write address valid.
  input wire logic       s_axi_awready,  // Write address ready.
  input wire logic       s_axi_wvalid,   // Write data valid.
  input wire logic       s_axi_wready,   // Write data ready.
  input wire logic       s_axi_bvalid,   // Write response valid.
  input wire logic       s_axi_arvalid,  // Read address valid.
  input wire logic       s_axi_arready,  // Read address ready.
  input wire logic       s_axi_rvalid    // Read data valid.
);
  logic flt;

  // Any of the four fault causes present.
  assign flt = pins.overcurrent_fault | pins.overload1_fault | pins.overload2_fault
             | pins.regen_fault;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Bus answers and busy windows.
  property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("awready back too early");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");

  // Alarm handling seen at the drive outputs.
  property p_base_off; $rose(flt) |-> ##[1:6] !drive.base_drive_on; endproperty
  a_base_off: assert property (p_base_off) else $error("base drive stayed on");
  property p_no_clear; flt && $past(flt, 8) |-> !drive.base_drive_on; endproperty
  a_no_clear: assert property (p_no_clear) else $error("alarm cleared with cause");
  property p_blk;
    drive.mode == CM_POSITION && flt && $past(flt, 8) |-> !drive.cmd_pulse_accept;
  endproperty
  a_blk: assert property (p_blk) else $error("pulse taken in alarm");

  // Mode change side effects.
  property p_droop;
    $past(drive.mode) == CM_POSITION && drive.mode == CM_TORQUE |-> ##[0:1] drive.droop_clear;
  endproperty
  a_droop: assert property (p_droop) else $error("droop not cleared");
  sequence s_tp_swap;
    ($past(drive.mode) == CM_TORQUE && drive.mode == CM_POSITION) ||
    ($past(drive.mode) == CM_POSITION && drive.mode == CM_TORQUE);
  endsequence
  property p_zero_gate; s_tp_swap |-> $past(pins.zero_speed_flag, 4); endproperty
  a_zero_gate: assert property (p_zero_gate) else $error("swap away from rest");
  property p_decel;
    (drive.mode == CM_SPEED && !pins.start_forward_input && !pins.start_reverse_input)[*8]
      |-> drive.decel_stop;
  endproperty
  a_decel: assert property (p_decel) else $error("no stop with starts off");

  // Main scenarios reached.
  c_alarm: cover property (pins.servo_on_input && !drive.base_drive_on);
  c_droop: cover property (drive.droop_clear);
  c_accept: cover property (drive.cmd_pulse_accept);
endmodule : sma_top_properties

bind sma_top sma_top_properties sma_top_properties_inst (
  .core_clk(core_clk), .rstn(rstn), .pins(pins), .drive(drive),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
